// ===== core/apsc_ctrl.sv
// Auxiliary pin, external selector and sync input control
`timescale 1ns/1ps
`include "apsc_regs.svh"

module apsc_ctrl
    import apsc_pkg::*;
#(
    parameter int SETTLE_W = `APSC_SETTLE_W
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic deferred_restart_select,
    input wire logic multi_chan_en,
    input wire logic [SETTLE_W-1:0] settle_cycles,
    input wire logic [3:0] seq_channel,
    input wire logic switch_due,
    input wire logic sync_in,
    input wire logic [1:0] gen_pin_data,
    input wire logic [1:0] gen_pin_drive,
    input wire logic [1:0] aux_data,
    output apsc_pins_t pin_out,
    output apsc_pins_t pin_oe_n,
    output logic conv_start,
    output logic mod_hold_reset,
    output logic pass_done
);

    //--------------------------------------------------------------
    // Configuration register
    //--------------------------------------------------------------
    apsc_cfg_t cfg_reg;
    apsc_cfg_t cfg_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic hit;

    function automatic logic [15:0] cfg_view(input apsc_cfg_t c);
        cfg_view = 16'(c) & `APSC_CFG_WMASK;
    endfunction : cfg_view

    always_comb
    begin
        hit = (reg_addr == `APSC_CFG_OFFSET);
        cfg_next = cfg_reg;
        if (reg_wr && hit)
        begin
            cfg_next = apsc_cfg_t'(reg_wdata & `APSC_CFG_WMASK);
        end
        rvalid_next = reg_rd;
        rdata_next = 16'h0000;
        if (reg_rd && hit)
        begin
            rdata_next = cfg_view(cfg_reg);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_reg <= apsc_cfg_t'(`APSC_CFG_RESET);
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    //--------------------------------------------------------------
    // Sync mode decode
    //--------------------------------------------------------------
    logic sync_en;
    logic deferred_mode;
    logic sel_drive;

    always_comb
    begin
        sync_en = cfg_reg.sync_input_enable;
        sel_drive = cfg_reg.external_selector_drive;
        deferred_mode = sync_en && deferred_restart_select
            && multi_chan_en;
    end

    //--------------------------------------------------------------
    // Channel switch sequencing
    //--------------------------------------------------------------
    apsc_state_t state_reg;
    apsc_state_t state_next;
    logic [SETTLE_W-1:0] cnt_reg;
    logic [SETTLE_W-1:0] cnt_next;
    logic [3:0] sel_reg;
    logic [3:0] sel_next;
    logic start_reg;
    logic start_next;
    logic pass_reg;
    logic pass_next;
    logic hold_reg;
    logic hold_next;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sel_next = sel_reg;
        start_next = 1'b0;
        pass_next = 1'b0;
        // Default sync mode: low level holds modulator and filter
        hold_next = sync_en && !deferred_mode && !sync_in;
        if (switch_due)
        begin
            sel_next = seq_channel;
            pass_next = (sel_reg == `APSC_LAST_CHANNEL);
        end
        case (state_reg)
            APSC_IDLE:
            begin
                if (switch_due)
                begin
                    if (deferred_mode && !sync_in)
                    begin
                        state_next = APSC_HOLD;
                    end
                    else if (settle_cycles != '0)
                    begin
                        state_next = APSC_SETTLE;
                        cnt_next = settle_cycles;
                    end
                    else
                    begin
                        start_next = 1'b1;
                    end
                end
            end
            APSC_SETTLE:
            begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg == SETTLE_W'(1))
                begin
                    state_next = APSC_IDLE;
                    start_next = 1'b1;
                end
            end
            APSC_HOLD:
            begin
                if (sync_in || !deferred_mode)
                begin
                    state_next = APSC_IDLE;
                    start_next = 1'b1;
                end
            end
            default:
            begin
                state_next = APSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= APSC_IDLE;
            cnt_reg <= '0;
            sel_reg <= 4'h0;
            start_reg <= 1'b0;
            pass_reg <= 1'b0;
            hold_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
            start_reg <= start_next;
            pass_reg <= pass_next;
            hold_reg <= hold_next;
        end
    end

    assign conv_start = start_reg;
    assign pass_done = pass_reg;
    assign mod_hold_reset = hold_reg;

    //--------------------------------------------------------------
    // Pin drive
    //--------------------------------------------------------------
    apsc_pins_t pout_reg;
    apsc_pins_t pout_next;
    apsc_pins_t poe_reg;
    apsc_pins_t poe_next;

    always_comb
    begin
        if (sel_drive)
        begin
            // Binary select index on all four pins
            pout_next = apsc_pins_t'(sel_next);
            poe_next = apsc_pins_t'(4'h0);
        end
        else
        begin
            pout_next.general_pin_zero = gen_pin_data[0];
            pout_next.general_pin_one = gen_pin_data[1];
            poe_next.general_pin_zero = !gen_pin_drive[0];
            poe_next.general_pin_one = !gen_pin_drive[1];
            pout_next.aux_output_a = cfg_reg.aux_output_pair_enable
                && aux_data[0];
            pout_next.aux_output_b = cfg_reg.aux_output_pair_enable
                && aux_data[1];
            poe_next.aux_output_a = !cfg_reg.aux_output_pair_enable;
            poe_next.aux_output_b = !cfg_reg.aux_output_pair_enable;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pout_reg <= apsc_pins_t'(4'h0);
            poe_reg <= apsc_pins_t'(4'hF);
        end
        else
        begin
            pout_reg <= pout_next;
            poe_reg <= poe_next;
        end
    end

    assign pin_out = pout_reg;
    assign pin_oe_n = poe_reg;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence held_switch_s;
        switch_due && state_reg == APSC_IDLE && deferred_mode && !sync_in;
    endsequence

    sequence release_s;
        state_reg == APSC_HOLD && sync_in;
    endsequence

    cfg_read_back_a: assert property (
        reg_rd && hit |=> reg_rvalid
        && reg_rdata == cfg_view($past(cfg_reg)))
        else $error("config read data wrong");

    reserved_zero_a: assert property (
        reg_rvalid |-> reg_rdata[15:14] == 2'b00)
        else $error("reserved bits not zero");

    aux_disabled_a: assert property (
        !sel_drive && !cfg_reg.aux_output_pair_enable
        ##1 !$past(sel_drive) |-> pin_oe_n.aux_output_a
        && pin_oe_n.aux_output_b && !pin_out.aux_output_a)
        else $error("aux pins driven while disabled");

    sel_index_a: assert property (
        sel_drive && switch_due
        |=> pin_out == apsc_pins_t'($past(seq_channel))
        && pin_oe_n == apsc_pins_t'(4'h0))
        else $error("selector index not on pins");

    default_hold_a: assert property (
        sync_en && !deferred_mode && !sync_in |=> mod_hold_reset)
        else $error("low sync did not hold converter");

    deferred_no_reset_a: assert property (
        deferred_mode && !sync_in |=> !mod_hold_reset)
        else $error("deferred mode reset converter");

    withhold_a: assert property (
        held_switch_s ##1 (!sync_in && deferred_mode) [*2]
        |-> !conv_start [*2])
        else $error("withheld conversion started");

    release_a: assert property (
        release_s |=> conv_start && state_reg == APSC_IDLE)
        else $error("release did not start conversion");

    settle_a: assert property (
        state_reg == APSC_IDLE && switch_due && !(deferred_mode && !sync_in)
        && settle_cycles == SETTLE_W'(2) |=> !conv_start ##1 !conv_start
        ##1 conv_start)
        else $error("settle delay length wrong");

    pass_wrap_a: assert property (
        switch_due && sel_reg == `APSC_LAST_CHANNEL |=> pass_done)
        else $error("pass end not flagged");

endmodule : apsc_ctrl

// ===== pkg/apsc_pkg.sv
// Types shared by the auxiliary pin and sync control block
package apsc_pkg;
    typedef struct packed {
        logic [1:0] reserved;
        logic aux_output_pair_enable;
        logic external_selector_drive;
        logic sync_input_enable;
        logic [10:0] other_fields;
    } apsc_cfg_t;

    typedef struct packed {
        logic aux_output_b;
        logic aux_output_a;
        logic general_pin_one;
        logic general_pin_zero;
    } apsc_pins_t;

    typedef enum logic [1:0] {
        APSC_IDLE,
        APSC_SETTLE,
        APSC_HOLD
    } apsc_state_t;
endpackage : apsc_pkg

// ===== pkg/apsc_regs.svh
// Register offsets, field positions, reset values and timing counts
//------------------------------------------------------------------
// Operation
//------------------------------------------------------------------
// Operation
// - Config register at offset 0x06, resets to 0x0800, sync enable set
// - Bit 13 enables both auxiliary outputs; resets to 0
// - Bit 12 drives four general pins as selects in step with sequencer
// - Analog pair per channel stays selectable while selector drive is on
// - At most 16 channels sequence per pass; host then moves the pair
// - Configurable settle delay after each channel switch not withheld by sync
// - Bit 11 (reset 1) enables sync input; low holds converter in reset
// - Deferred mode needs several channels; low sync gives no reset
// - Deferred mode: sync low at channel switch withholds next conversion
// - Sync going high releases a withheld channel; conversion starts at once
`ifndef APSC_REGS_SVH
`define APSC_REGS_SVH
`define APSC_CFG_OFFSET 8'h06
`define APSC_CFG_RESET 16'h0800
`define APSC_CFG_WMASK 16'h3FFF
`define APSC_BIT_AUX_EN 13
`define APSC_BIT_SEL_DRIVE 12
`define APSC_BIT_SYNC_EN 11
`define APSC_LAST_CHANNEL 4'hF
`define APSC_SETTLE_W 16
`endif

// ===== testbench/apsc_far_model.sv
// Model of the external selector and the external sync controller
`timescale 1ns/1ps

module apsc_far_model
    import apsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sync_hold_req,
    input wire apsc_pins_t pin_out,
    input wire apsc_pins_t pin_oe_n,
    output logic sync_in,
    output logic [3:0] mux_sel
);
    logic [3:0] last_sel = 4'h0;

    initial sync_in = 1'h1;

    //------------------------------------------------------------------
    // Sync controller and selector
    //------------------------------------------------------------------
    // Dropping the hold request drives sync high to free a held channel
    always @(posedge core_clk)
        sync_in <= !sync_hold_req;

    // Undriven select pins float, so show the inverse of the last level
    always @(posedge core_clk)
        if (pin_oe_n === 4'h0)
            last_sel <= pin_out;

    assign mux_sel = (pin_oe_n === 4'h0) ? pin_out : ~last_sel;
endmodule : apsc_far_model

// ===== testbench/tb.sv
// Self-checking bench for the aux pin and sync control block
`timescale 1ns/1ps

module tb;
    import apsc_pkg::*;
    logic core_clk = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic deferred_restart_select = 1'h0;
    logic multi_chan_en = 1'h0;
    logic [15:0] settle_cycles = 16'h0000;
    logic [3:0] seq_channel = 4'h0;
    logic switch_due = 1'h0;
    logic sync_hold_req = 1'h0;
    logic sync_in;
    logic [1:0] gen_pin_data = 2'h0;
    logic [1:0] gen_pin_drive = 2'h0;
    logic [1:0] aux_data = 2'h0;
    apsc_pins_t pin_out;
    apsc_pins_t pin_oe_n;
    logic conv_start;
    logic mod_hold_reset;
    logic pass_done;
    logic [3:0] mux_sel;
    int n_fail = 0;
    int check_count = 0;
    int n;

    always #5 core_clk = ~core_clk;

    apsc_ctrl dut_u (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .reg_rvalid, .deferred_restart_select,
        .multi_chan_en, .settle_cycles, .seq_channel, .switch_due, .sync_in,
        .gen_pin_data, .gen_pin_drive, .aux_data, .pin_out, .pin_oe_n,
        .conv_start, .mod_hold_reset, .pass_done);

    apsc_far_model far_u (.core_clk, .sync_hold_req, .pin_out, .pin_oe_n,
        .sync_in, .mux_sel);

    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    task automatic give_verdict;
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic edges(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : edges

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        check({15'h0000, reg_rvalid}, 16'h0001);
        check(reg_rdata, exp);
    endtask : reg_read

    task automatic sw(input logic [3:0] ch, input logic [15:0] st);
        @(posedge core_clk);
        seq_channel <= ch;
        settle_cycles <= st;
        switch_due <= 1'h1;
        @(posedge core_clk);
        switch_due <= 1'h0;
        #1;
    endtask : sw

    task automatic wait_start(input int lim);
        n = 0;
        while (conv_start !== 1'h1 && n < lim)
        begin
            edges(1);
            n++;
        end
        if (conv_start !== 1'h1)
        begin
            n_fail++;
            give_verdict();
        end
    endtask : wait_start

    //------------------------------------------------------------------
    // Sequence
    //------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'h1;
        reg_read(8'h06, 16'h0800);
        reg_read(8'h05, 16'h0000);
        reg_write(8'h06, 16'hFFFF);
        reg_read(8'h06, 16'h3FFF);
        reg_write(8'h05, 16'h0000);
        reg_read(8'h06, 16'h3FFF);
        @(posedge core_clk);
        aux_data <= 2'h2;
        gen_pin_drive <= 2'h1;
        gen_pin_data <= 2'h1;
        reg_write(8'h06, 16'h2800);
        edges(2);
        check({12'h000, pin_oe_n}, 16'h0002);
        check({14'h0000, pin_out[3], pin_out[0]}, 16'h0003);
        reg_write(8'h06, 16'h0800);
        edges(2);
        check({12'h000, pin_oe_n}, 16'h000E);
        reg_write(8'h06, 16'h1800);
        sw(4'h5, 16'h0002);
        check({12'h000, mux_sel}, 16'h0005);
        wait_start(20);
        check(n[15:0], 16'h0002);
        sw(4'hF, 16'h0000);
        check({12'h000, mux_sel}, 16'h000F);
        check({15'h0000, pass_done}, 16'h0000);
        wait_start(20);
        check(n[15:0], 16'h0000);
        sw(4'h0, 16'h0000);
        check({15'h0000, pass_done}, 16'h0001);
        wait_start(20);
        @(posedge core_clk);
        sync_hold_req <= 1'h1;
        edges(3);
        check({15'h0000, mod_hold_reset}, 16'h0001);
        @(posedge core_clk);
        sync_hold_req <= 1'h0;
        edges(3);
        check({15'h0000, mod_hold_reset}, 16'h0000);
        @(posedge core_clk);
        deferred_restart_select <= 1'h1;
        multi_chan_en <= 1'h1;
        sync_hold_req <= 1'h1;
        edges(3);
        sw(4'h3, 16'h0000);
        repeat (5)
        begin
            check({15'h0000, conv_start | mod_hold_reset}, 16'h0000);
            edges(1);
        end
        @(posedge core_clk);
        sync_hold_req <= 1'h0;
        #1;
        wait_start(6);
        check({15'h0000, n <= 3}, 16'h0001);
        @(posedge core_clk);
        multi_chan_en <= 1'h0;
        sync_hold_req <= 1'h1;
        edges(3);
        check({15'h0000, mod_hold_reset}, 16'h0001);
        give_verdict();
    end
endmodule : tb
